// >>> design/ifc_flag_bank.sv
/*
 One bank of sticky interrupt flags for one output line.
 Assumes event inputs are one-cycle pulses synchronous to pclk and that the
 clear strobe is already qualified by a completed bus write.
*/
`timescale 1ns/1ps
module ifc_flag_bank (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic [31:0] event_in,
	input  wire logic [31:0] enable,
	input  wire logic        clear_we,
	input  wire logic [31:0] clear_bits,
	output logic      [31:0] flags_q
);
	import ifc_pkg::*;

	logic [31:0] set_bits;
	logic [31:0] flags_d;

	always_comb
	begin
		// Only enabled sources may latch a flag
		set_bits = event_in & enable & FLAG_VALID;
		flags_d  = flags_q;
		if (clear_we)
			flags_d = flags_d & ~clear_bits;
		// Set after clear so a same-cycle event is never lost
		flags_d = flags_d | set_bits;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flags_q <= FLAGS_RESET;
		else if (ce)
			flags_q <= flags_d;
	end
endmodule

// >>> design/ifc_pkg.sv
/*
 Package for the interrupt enable and flag block: register offsets, reset values,
 bit positions of the named sources and the mask of implemented flag bits.
 Assumes a 16-bit APB byte address with 32-bit data.
*/
package ifc_pkg;
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 32;

	// Register byte offsets
	localparam logic [15:0] OFF_POLARITY    = 16'h3000;
	localparam logic [15:0] OFF_CLEAR       = 16'h3004;
	localparam logic [15:0] OFF_SELECT0     = 16'h3008;
	localparam logic [15:0] OFF_SELECT1     = 16'h300c;
	localparam logic [15:0] OFF_FLAGS0      = 16'h3010;
	localparam logic [15:0] OFF_FLAGS1      = 16'h3014;
	localparam logic [15:0] OFF_SYS_STATUS  = 16'h3018;
	localparam logic [15:0] OFF_SYS_MASK    = 16'h301c;

	// Reset values
	localparam logic [31:0] SELECT_RESET    = 32'h0000_2000;
	localparam logic [31:0] FLAGS_RESET     = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
	localparam logic [2:0]  SYS_RESET       = 3'h0;

	// Flag bits that exist; reserved flag bits read as zero
	localparam logic [31:0] FLAG_VALID      = 32'haf83_bfff;

	// Source bit positions
	localparam int          BIT_ADC_RESULT  = 0;
	localparam int          BIT_DFT_RESULT  = 1;
	localparam int          BIT_SINC2_READY = 2;
	localparam int          BIT_TEMP_RESULT = 3;
	localparam int          BIT_ADC_MAX     = 5;
	localparam int          BIT_ADC_DELTA   = 6;
	localparam int          BIT_CUSTOM0     = 9;
	localparam int          BIT_CUSTOM3     = 12;
	localparam int          BIT_BOOT_DONE   = 13;
	localparam int          BIT_END_OF_SEQ  = 15;
	localparam int          BIT_FIFO_EMPTY  = 24;
	localparam int          BIT_FIFO_THRESH = 25;
	localparam int          BIT_FIFO_OVF    = 26;
	localparam int          BIT_FIFO_UNF    = 27;
	localparam int          BIT_COLLISION   = 31;

	// System status bits
	localparam int          SYS_OUT0        = 0;
	localparam int          SYS_OUT1        = 1;
	localparam int          SYS_COLLIDE     = 2;
	localparam int          SYS_W           = 3;
endpackage

// >>> design/ifc_top.sv
/*
 Interrupt enable and flag logic with an APB register slave, two edge-signalled
 interrupt output pins and a masked summary interrupt.
 Assumes source events are one-cycle pulses synchronous to pclk, the sequencer
 gives a running level and a start request pulse, and pclk runs at 40 MHz.
*/
// The APB register port was decided locally.
`timescale 1ns/1ps
// What this block does
// - Source reaches output only when enabled
// - Boot-done enable resets to one, others zero
// - Delta-fail enable bit 6, max-fail bit 5
// - Four custom sources, highest at bit 12
// - Sinc2, DFT, ADC, temperature have enables
// - Collision sets bit 31, request dropped
// - Flags read-only, underflow at bit 27
// - FIFO overflow, threshold, empty at 26-24
// - Two flag registers, zero after reset
// - Writing one to clear register clears flag
// - Polarity picks falling or rising output edge
// - Flag bank zero drives output zero
module ifc_top (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      ce,
	input  wire logic [ifc_pkg::ADDR_W-1:0] paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [ifc_pkg::DATA_W-1:0] pwdata,
	output logic      [ifc_pkg::DATA_W-1:0] prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [ifc_pkg::DATA_W-1:0] src_event,
	input  wire logic                      seq_b_request,
	input  wire logic                      seq_a_running,
	output logic                           seq_b_start,
	output logic                           int_out0,
	output logic                           int_out1,
	output logic                           irq
);
	import ifc_pkg::*;

	logic [31:0]      select0_q;
	logic [31:0]      select1_q;
	logic             polarity_q;
	logic [SYS_W-1:0] sys_status_q;
	logic [SYS_W-1:0] sys_mask_q;
	logic [31:0]      flags0;
	logic [31:0]      flags1;
	logic             any0_prev_q;
	logic             any1_prev_q;
	logic [31:0]      prdata_q;
	logic             pready_q;
	logic             pslverr_q;
	logic             seq_b_start_q;
	logic             int_out0_q;
	logic             int_out1_q;
	logic             irq_q;

	logic             setup;
	logic             wr_done;
	logic             addr_hit;
	logic [31:0]      read_mux;
	logic             collision;
	logic [31:0]      events;
	logic             clear_we;
	logic             any0;
	logic             any1;
	logic [SYS_W-1:0] sys_set;

	assign prdata      = prdata_q;
	assign pready      = pready_q;
	assign pslverr     = pslverr_q;
	assign seq_b_start = seq_b_start_q;
	assign int_out0    = int_out0_q;
	assign int_out1    = int_out1_q;
	assign irq         = irq_q;

	// Bus phases
	assign setup   = psel & ~penable;
	assign wr_done = psel & penable & pready_q & pwrite;
	assign clear_we = wr_done & (paddr == OFF_CLEAR);

	always_comb
	begin
		addr_hit = 1'b1;
		read_mux = ZERO_WORD;
		unique case (paddr)
			OFF_POLARITY:   read_mux = {31'h0000_0000, polarity_q};
			OFF_CLEAR:      read_mux = ZERO_WORD;
			OFF_SELECT0:    read_mux = select0_q;
			OFF_SELECT1:    read_mux = select1_q;
			OFF_FLAGS0:     read_mux = flags0;
			OFF_FLAGS1:     read_mux = flags1;
			OFF_SYS_STATUS: read_mux = {29'h0000_0000, sys_status_q};
			OFF_SYS_MASK:   read_mux = {29'h0000_0000, sys_mask_q};
			default:        addr_hit = 1'b0;
		endcase
	end

	// Answer is prepared in the setup cycle so the access phase has no wait state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			prdata_q  <= ZERO_WORD;
			pslverr_q <= 1'b0;
		end
		else if (ce)
		begin
			pready_q  <= setup;
			pslverr_q <= setup & ~addr_hit;
			if (setup && !pwrite)
				prdata_q <= read_mux;
		end
	end

	// Enable registers; reserved bits are kept as plain storage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			select0_q <= SELECT_RESET;
			select1_q <= SELECT_RESET;
		end
		else if (ce && wr_done)
		begin
			if (paddr == OFF_SELECT0)
				select0_q <= pwdata;
			if (paddr == OFF_SELECT1)
				select1_q <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			polarity_q <= 1'b0;
			sys_mask_q <= SYS_RESET;
		end
		else if (ce && wr_done)
		begin
			if (paddr == OFF_POLARITY)
				polarity_q <= pwdata[0];
			if (paddr == OFF_SYS_MASK)
				sys_mask_q <= pwdata[SYS_W-1:0];
		end
	end

	// A second-sequence request during a running first sequence is dropped
	assign collision = seq_b_request & seq_a_running;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			seq_b_start_q <= 1'b0;
		else if (ce)
			seq_b_start_q <= seq_b_request & ~seq_a_running;
	end

	// Bit 31 is owned by the collision detector, not by the source port
	assign events = {collision, src_event[30:0]};

	ifc_flag_bank u_bank0 (
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (ce),
		.event_in   (events),
		.enable     (select0_q),
		.clear_we   (clear_we),
		.clear_bits (pwdata),
		.flags_q    (flags0)
	);

	ifc_flag_bank u_bank1 (
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (ce),
		.event_in   (events),
		.enable     (select1_q),
		.clear_we   (clear_we),
		.clear_bits (pwdata),
		.flags_q    (flags1)
	);

	assign any0 = |flags0;
	assign any1 = |flags1;

	// Pin idles at the inactive level; changing polarity while idle makes an edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_out0_q <= 1'b1;
			int_out1_q <= 1'b1;
		end
		else if (ce)
		begin
			int_out0_q <= any0 ? polarity_q : ~polarity_q;
			int_out1_q <= any1 ? polarity_q : ~polarity_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			any0_prev_q <= 1'b0;
			any1_prev_q <= 1'b0;
		end
		else if (ce)
		begin
			any0_prev_q <= any0;
			any1_prev_q <= any1;
		end
	end

	always_comb
	begin
		sys_set              = SYS_RESET;
		sys_set[SYS_OUT0]    = any0 & ~any0_prev_q;
		sys_set[SYS_OUT1]    = any1 & ~any1_prev_q;
		sys_set[SYS_COLLIDE] = collision;
	end

	// Sticky summary status, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sys_status_q <= SYS_RESET;
		else if (ce)
		begin
			if (wr_done && paddr == OFF_SYS_STATUS)
				sys_status_q <= (sys_status_q & ~pwdata[SYS_W-1:0]) | sys_set;
			else
				sys_status_q <= sys_status_q | sys_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_q <= 1'b0;
		else if (ce)
			irq_q <= |(sys_status_q & sys_mask_q);
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_enable_gates_flag: assert property (
		ce |=> ((flags0 & ~$past(flags0) & ~$past(select0_q)) == ZERO_WORD))
		else $error("flag0 set while its enable was low");

	chk_boot_enable_reset: assert property (
		$rose(presetn) |-> (select0_q == SELECT_RESET && select1_q == SELECT_RESET))
		else $error("select reset value wrong");

	chk_delta_fail_set: assert property (
		ce && events[BIT_ADC_DELTA] && select0_q[BIT_ADC_DELTA] |=> flags0[BIT_ADC_DELTA])
		else $error("delta fail flag not set");

	chk_custom3_set: assert property (
		ce && events[BIT_CUSTOM3] && select1_q[BIT_CUSTOM3] |=> flags1[BIT_CUSTOM3])
		else $error("custom 3 flag not set on bank one");

	chk_adc_result_set: assert property (
		ce && events[BIT_ADC_RESULT] && select1_q[BIT_ADC_RESULT]
		|=> flags1[BIT_ADC_RESULT])
		else $error("adc result flag not set");

	chk_collision_drop: assert property (
		ce && collision |=> !seq_b_start_q && sys_status_q[SYS_COLLIDE])
		else $error("colliding request not dropped");

	chk_flags_hold: assert property (
		ce && !clear_we |=> (($past(flags0) & ~flags0) == ZERO_WORD))
		else $error("flag0 fell without a clear write");

	chk_fifo_ovf_set: assert property (
		ce && events[BIT_FIFO_OVF] && select0_q[BIT_FIFO_OVF] |=> flags0[BIT_FIFO_OVF])
		else $error("fifo overflow flag not set");

	chk_flag1_readback: assert property (
		ce && setup && !pwrite && paddr == OFF_FLAGS1
		|=> pready_q && prdata_q == $past(flags1))
		else $error("flag1 read data wrong");

	chk_clear_works: assert property (
		ce && clear_we && pwdata[BIT_END_OF_SEQ] && !events[BIT_END_OF_SEQ]
		|=> !flags0[BIT_END_OF_SEQ] && !flags1[BIT_END_OF_SEQ])
		else $error("end of sequence flag not cleared");

	chk_pin_level: assert property (
		ce && any0 |=> int_out0_q == $past(polarity_q))
		else $error("output zero at wrong level");

	chk_summary_irq: assert property (
		ce && |(sys_status_q & sys_mask_q) |=> irq_q)
		else $error("summary interrupt missing");

	chk_out0_idle_level: assert property (
		ce && !any0 |=> int_out0_q == !$past(polarity_q))
		else $error("output zero active with bank zero empty");

	chk_out1_active_level: assert property (
		ce && any1 |=> int_out1_q == $past(polarity_q))
		else $error("output one not active with bank one pending");

	chk_flags1_hold: assert property (
		ce && !clear_we |=> (($past(flags1) & ~flags1) == ZERO_WORD))
		else $error("flag1 fell without a clear write");

	chk_reserved_flags_zero: assert property (
		((flags0 | flags1) & ~FLAG_VALID) == ZERO_WORD)
		else $error("reserved flag bit set");

	chk_bank1_sets_enabled: assert property (
		ce |=> ((flags1 & $past(events) & $past(select1_q) & FLAG_VALID)
			== ($past(events) & $past(select1_q) & FLAG_VALID)))
		else $error("enabled event did not set flag1");

	chk_fifo_unf_set: assert property (
		ce && events[BIT_FIFO_UNF] && select1_q[BIT_FIFO_UNF] |=> flags1[BIT_FIFO_UNF])
		else $error("fifo underflow flag not set");

	chk_seq_start_pass: assert property (
		ce && seq_b_request && !seq_a_running |=> seq_b_start_q)
		else $error("accepted request not started");

	chk_apb_no_wait: assert property (
		ce && setup |=> pready_q)
		else $error("access phase without ready");

	chk_unmapped_error: assert property (
		ce && setup && !addr_hit |=> pready_q && pslverr_q)
		else $error("unmapped address without error");

	cov_collision: cover property (ce && collision);
	cov_clear_flag: cover property (clear_we && |(flags0 & pwdata));
	cov_out1_edge: cover property ($changed(int_out1_q));
	cov_unmapped: cover property (pslverr_q);
	cov_custom3_flag: cover property (ce && events[BIT_CUSTOM3] && select0_q[BIT_CUSTOM3]);
endmodule

// >>> tb/ifc_host_model.sv
/*
 Host model: counts active edges seen on each interrupt output line.
 Assumes the bench tells it the programmed polarity.
*/
`timescale 1ns/1ps
module ifc_host_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pol,
	input  wire logic line0,
	input  wire logic line1,
	output int        hits0,
	output int        hits1
);
	logic l0_q;
	logic l1_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			l0_q <= 1'b1;
			l1_q <= 1'b1;
			hits0 <= 0;
			hits1 <= 0;
		end
		else
		begin
			l0_q <= line0;
			l1_q <= line1;
			// Only a move into the active level is serviced
			if (line0 == pol && l0_q != pol)
				hits0 <= hits0 + 1;
			if (line1 == pol && l1_q != pol)
				hits1 <= hits1 + 1;
		end
	end
endmodule

// >>> tb/testbench.sv
/*
 Self-checking bench for ifc_top: APB tasks, random event bursts, source
 sweep, collision, pin polarity and summary interrupt.
 Assumes ifc_host_model and a 40 MHz pclk.
*/
`timescale 1ns/1ps
module testbench;
	import ifc_pkg::*;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, pol;
	logic        seq_b_request, seq_a_running, seq_b_start, int_out0, int_out1, irq;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, src_event, rd, s0, s1, ev;
	int          fails, comparisons, hits0, hits1, h;
	integer      seed;
	int          bits[13] = '{15, 13, 12, 11, 10, 9, 6, 5, 3, 2, 1, 0, 27};

	ifc_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_event(src_event),
		.seq_b_request(seq_b_request), .seq_a_running(seq_a_running),
		.seq_b_start(seq_b_start), .int_out0(int_out0), .int_out1(int_out1), .irq(irq));
	ifc_host_model u_host (.pclk(pclk), .presetn(presetn), .pol(pol), .line0(int_out0),
		.line1(int_out1), .hits0(hits0), .hits1(hits1));

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait as long as the slave needs; only the watchdog ends a hang
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse(input logic [31:0] e);
		@(posedge pclk);
		src_event <= e;
		@(posedge pclk);
		src_event <= 32'h0;
		repeat (3) @(posedge pclk);
	endtask

	// Bit 31 of the event input is ignored; it is set only by a collision
	function automatic logic [31:0] exp_flags(input logic [31:0] e, input logic [31:0] s);
		return e & s & FLAG_VALID & 32'h7fff_ffff;
	endfunction

	initial
	begin
		seed = 32'hc6eb;
		{presetn, psel, penable, pwrite, seq_b_request, seq_a_running, pol} = 7'h0;
		{paddr, pwdata, src_event} = '0;
		ce = 1'b1;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_SELECT0, 32'h0);
		check(rd, SELECT_RESET);
		apb(1'b0, OFF_SELECT1, 32'h0);
		check(rd, SELECT_RESET);
		apb(1'b0, OFF_FLAGS1, 32'h0);
		check(rd, FLAGS_RESET);
		apb(1'b0, 16'h3020, 32'h0);
		check(32'(err), 32'h1);
		$display("reset test done");
		for (int i = 0; i < 13; i++)
		begin
			apb(1'b1, OFF_SELECT0, 32'h1 << bits[i]);
			pulse(32'hffff_ffff);
			apb(1'b0, OFF_FLAGS0, 32'h0);
			check(rd, 32'h1 << bits[i]);
			apb(1'b1, OFF_CLEAR, 32'hffff_ffff);
			apb(1'b1, OFF_SELECT0, ~(32'h1 << bits[i]));
			pulse(32'h1 << bits[i]);
			apb(1'b0, OFF_FLAGS0, 32'h0);
			check(rd, 32'h0);
		end
		$display("source sweep done");
		repeat (12)
		begin
			s0 = $random(seed);
			s1 = $random(seed) | 32'h0f00_0000;
			ev = $random(seed);
			apb(1'b1, OFF_SELECT0, s0);
			apb(1'b1, OFF_SELECT1, s1);
			apb(1'b0, OFF_SELECT0, 32'h0);
			check(rd, s0);
			h = hits0;
			pulse(ev);
			apb(1'b0, OFF_FLAGS0, 32'h0);
			check(rd, exp_flags(ev, s0));
			check(32'(hits0 - h), 32'(exp_flags(ev, s0) != 0));
			apb(1'b0, OFF_FLAGS1, 32'h0);
			check(rd, exp_flags(ev, s1));
			check(32'(int_out1), 32'(exp_flags(ev, s1) == 0));
			apb(1'b1, OFF_FLAGS1, 32'hffff_ffff);
			apb(1'b0, OFF_FLAGS1, 32'h0);
			check(rd, exp_flags(ev, s1));
			apb(1'b1, OFF_CLEAR, 32'hffff_ffff);
			apb(1'b0, OFF_FLAGS1, 32'h0);
			check(rd, 32'h0);
		end
		$display("random test done");
		apb(1'b1, OFF_POLARITY, 32'h1);
		pol <= 1'b1;
		apb(1'b1, OFF_SELECT0, 32'h8000_1000);
		h = hits0;
		pulse(32'h0000_1000);
		check(32'(int_out0), 32'h1);
		check(32'(hits0 - h), 32'h1);
		apb(1'b1, OFF_CLEAR, 32'hffff_ffff);
		@(posedge pclk);
		seq_a_running <= 1'b1;
		seq_b_request <= 1'b1;
		@(posedge pclk);
		seq_b_request <= 1'b0;
		@(posedge pclk);
		check(32'(seq_b_start), 32'h0);
		apb(1'b0, OFF_FLAGS0, 32'h0);
		check(rd, 32'h8000_0000);
		seq_a_running <= 1'b0;
		seq_b_request <= 1'b1;
		@(posedge pclk);
		seq_b_request <= 1'b0;
		@(posedge pclk);
		check(32'(seq_b_start), 32'h1);
		// A frozen clock enable must swallow an enabled event
		ce <= 1'b0;
		pulse(32'h0000_1000);
		ce <= 1'b1;
		apb(1'b0, OFF_FLAGS0, 32'h0);
		check(rd, 32'h8000_0000);
		$display("collision test done");
		apb(1'b1, OFF_CLEAR, 32'hffff_ffff);
		apb(1'b1, OFF_SYS_STATUS, 32'h7);
		apb(1'b1, OFF_SELECT0, 32'h1);
		// Bank one left over from the random test must not raise its own summary bit
		apb(1'b1, OFF_SELECT1, 32'h0);
		pulse(32'h1);
		apb(1'b0, OFF_SYS_STATUS, 32'h0);
		check(rd, 32'h1);
		check(32'(irq), 32'h0);
		apb(1'b1, OFF_SYS_MASK, 32'h1);
		repeat (3) @(posedge pclk);
		check(32'(irq), 32'h1);
		apb(1'b1, OFF_SYS_STATUS, 32'h1);
		repeat (3) @(posedge pclk);
		check(32'(irq), 32'h0);
		$display("summary interrupt test done");
		// Reset again with flags, enables and polarity away from their reset values
		presetn <= 1'b0;
		pol <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_FLAGS0, 32'h0);
		check(rd, FLAGS_RESET);
		apb(1'b0, OFF_SELECT1, 32'h0);
		check(rd, SELECT_RESET);
		check(32'(irq), 32'h0);
		check(32'(int_out0), 32'h1);
		$display("second reset test done");
		close_out();
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		fails++;
		close_out();
	end
endmodule
